// ---- tism_irq.sv ----
// Summary of operation
// - masked events still set status bits
// - mask lo at 08h, init..field exit
// - mask hi at 09h, rx start..access error
// - mask bits 4,3 default from config block
// - status lo bit7 on power-up/field/commands
// - status lo bit6 on selected entry
// - status lo bit5 on sleep request
// - status lo bit4 on reader write
// - status lo bit3 on reader read
// - status lo bit2 on buffered rx end
// - status lo bit1 on buffered tx end
// - status lo at 0Ah, bit0 field exit
// - status hi at 0Bh, bit7 buffered rx start
// - status hi bits 6,5,4 on rx errors
// - status hi bit3 on buffer fault
// - status hi bit2 on host write done
// - status hi bit1 on protected/missing write
// - status hi bit0 on access control abort
// - reading status clears it afterwards
// - power-up and set-default clear status
// - buffer under/overflow raise buffer fault
module tism_irq
	import tism_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// internal register port from the host serial interface
	input wire logic regSel,
	input wire logic regWrite,
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic regRvalid,
	// configuration block and device commands
	input wire logic nvmCfgValid,
	input wire logic [7:0] nvm_mask_cfg_lo,
	input wire logic [7:0] nvm_mask_cfg_hi,
	input wire logic cmdSetDefault,
	// event pulses, one cycle each
	input wire logic evtInit,
	input wire logic evt_selected_wake,
	input wire logic evtSleepReq,
	input wire logic evt_reader_write,
	input wire logic evt_reader_read,
	input wire logic evtRxEnd,
	input wire logic evtTxEnd,
	input wire logic evtFieldExit,
	input wire logic evtRxStart,
	input wire logic evtFrameErr,
	input wire logic evtParityErr,
	input wire logic evtCrcErr,
	input wire logic evtBufUnderflow,
	input wire logic evtBufOverflow,
	input wire logic evtHostWrDone,
	input wire logic evtNvmAccErr,
	input wire logic evtAccCtrlErr,
	// qualifiers from the frame path
	input wire logic rxToBuffer,
	input wire logic txFromBuffer,
	// interrupt line toward the host, active high
	output logic irqOut
);
	typedef struct packed {
		logic [7:0] maskLo;
		logic [7:0] maskHi;
		logic [7:0] statLo;
		logic [7:0] statHi;
		logic [7:0] rdata;
		logic rvalid;
		logic irq;
	} tism_state_t;

	tism_state_t st;
	tism_state_t next_st;
	logic [7:0] setLo;
	logic [7:0] setHi;

	// merge a configuration byte into the nvm-loaded mask bits
	function automatic logic [7:0] tism_mask_dflt(
		input logic [7:0] fixedVal,
		input logic [7:0] cfg
	);
		tism_mask_dflt = (fixedVal & ~MASK_NVM_BITS) | (cfg & MASK_NVM_BITS);
	endfunction : tism_mask_dflt

	// event to bit mapping; masks never gate this path
	always_comb begin
		setLo = 8'h00;
		setHi = 8'h00;
		setLo[BIT_INIT] = evtInit;
		setLo[BIT_SEL_WAKE] = evt_selected_wake;
		setLo[BIT_SLEEP_REQ] = evtSleepReq;
		setLo[BIT_RDR_WRITE] = evt_reader_write;
		setLo[BIT_RDR_READ] = evt_reader_read;
		setLo[BIT_RX_END] = evtRxEnd & rxToBuffer;
		setLo[BIT_TX_END] = evtTxEnd & txFromBuffer;
		setLo[BIT_FIELD_EXIT] = evtFieldExit;
		setHi[BIT_RX_START] = evtRxStart & rxToBuffer;
		// errors flag only; the frame path still stores the data
		setHi[BIT_FRAME_ERR] = evtFrameErr;
		setHi[BIT_PARITY_ERR] = evtParityErr;
		setHi[BIT_CRC_ERR] = evtCrcErr;
		setHi[BIT_BUF_FAULT] = evtBufUnderflow | evtBufOverflow;
		setHi[BIT_HOST_WR_DONE] = evtHostWrDone;
		setHi[BIT_NVM_ACC_ERR] = evtNvmAccErr;
		setHi[BIT_ACC_CTRL_ERR] = evtAccCtrlErr;
	end

	// register port, status capture and interrupt line
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		// reads return the pre-clear value, then clear; set beats clear
		if (regSel && !regWrite) begin
			next_st.rvalid = 1'b1;
			unique case (regAddr)
				OFS_MASK_LO: next_st.rdata = st.maskLo;
				OFS_MASK_HI: next_st.rdata = st.maskHi;
				OFS_STAT_LO: begin
					next_st.rdata = st.statLo;
					next_st.statLo = STAT_RESET;
				end
				OFS_STAT_HI: begin
					next_st.rdata = st.statHi;
					next_st.statHi = STAT_RESET;
				end
				default: next_st.rdata = 8'h00;
			endcase
		end
		if (regSel && regWrite) begin
			if (regAddr == OFS_MASK_LO) begin
				next_st.maskLo = regWdata;
			end
			if (regAddr == OFS_MASK_HI) begin
				next_st.maskHi = regWdata;
			end
		end
		// set-default reloads mask bits 4,3 from config and clears status
		if (cmdSetDefault) begin
			next_st.statLo = STAT_RESET;
			next_st.statHi = STAT_RESET;
			next_st.maskLo = tism_mask_dflt(next_st.maskLo, nvm_mask_cfg_lo);
			next_st.maskHi = tism_mask_dflt(next_st.maskHi, nvm_mask_cfg_hi);
		end
		// configuration block arrives after power-up; load nvm bits
		if (nvmCfgValid) begin
			next_st.maskLo = tism_mask_dflt(next_st.maskLo, nvm_mask_cfg_lo);
			next_st.maskHi = tism_mask_dflt(next_st.maskHi, nvm_mask_cfg_hi);
		end
		// events set regardless of mask and win over any clear
		next_st.statLo = next_st.statLo | setLo;
		next_st.statHi = next_st.statHi | setHi;
		// line is registered alongside status, so it changes in the same cycle
		next_st.irq = |(next_st.statLo & ~next_st.maskLo)
			| |(next_st.statHi & ~next_st.maskHi);
	end

	// single state register; reset stands for power-up
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st.maskLo <= MASK_LO_RESET;
			st.maskHi <= MASK_HI_RESET;
			st.statLo <= STAT_RESET;
			st.statHi <= STAT_RESET;
			st.rdata <= 8'h00;
			st.rvalid <= 1'b0;
			st.irq <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign regRdata = st.rdata;
	assign regRvalid = st.rvalid;
	assign irqOut = st.irq;
endmodule : tism_irq

// ---- tism_pkg.sv ----
package tism_pkg;
	// register offsets on the internal register port
	localparam logic [4:0] OFS_MASK_LO = 5'h08;
	localparam logic [4:0] OFS_MASK_HI = 5'h09;
	localparam logic [4:0] OFS_STAT_LO = 5'h0A;
	localparam logic [4:0] OFS_STAT_HI = 5'h0B;
	// status low bit positions
	localparam int BIT_INIT = 7;
	localparam int BIT_SEL_WAKE = 6;
	localparam int BIT_SLEEP_REQ = 5;
	localparam int BIT_RDR_WRITE = 4;
	localparam int BIT_RDR_READ = 3;
	localparam int BIT_RX_END = 2;
	localparam int BIT_TX_END = 1;
	localparam int BIT_FIELD_EXIT = 0;
	// status high bit positions
	localparam int BIT_RX_START = 7;
	localparam int BIT_FRAME_ERR = 6;
	localparam int BIT_PARITY_ERR = 5;
	localparam int BIT_CRC_ERR = 4;
	localparam int BIT_BUF_FAULT = 3;
	localparam int BIT_HOST_WR_DONE = 2;
	localparam int BIT_NVM_ACC_ERR = 1;
	localparam int BIT_ACC_CTRL_ERR = 0;
	// mask bits that take their default from the configuration block
	localparam logic [7:0] MASK_NVM_BITS = 8'h18;
	// fixed mask defaults for all other bits, then the status reset value
	localparam logic [7:0] MASK_LO_RESET = 8'h00;
	localparam logic [7:0] MASK_HI_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h00;
endpackage : tism_pkg

// ---- tism_irq_monitor.sv ----
module tism_irq_monitor
	import tism_pkg::*;
(
	// watched ports
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic regSel,
	input wire logic regWrite,
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic regRvalid,
	input wire logic evtFieldExit,
	input wire logic irqOut
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// decode; mask bits 4,3 may reload from config, so skipped
	wire logic rd = regSel && !regWrite;
	wire logic wr = regSel && regWrite;
	read_ack_a: assert property (rd |=> regRvalid)
		else $error("read unanswered");
	write_quiet_a: assert property (wr |=> !regRvalid)
		else $error("write answered");
	ack_cause_a: assert property (regRvalid |-> $past(rd))
		else $error("stray answer");
	mask_back_a: assert property (wr && regAddr == OFS_MASK_HI ##1 rd
		&& regAddr == OFS_MASK_HI |=> ((regRdata ^ $past(regWdata, 2))
		& ~MASK_NVM_BITS) == 8'h00) else $error("mask readback");
	exit_flag_a: assert property (evtFieldExit ##1 rd
		&& regAddr == OFS_STAT_LO |=> regRdata[BIT_FIELD_EXIT])
		else $error("exit lost");
	unmapped_zero_a: assert property (rd && regAddr[4:2] != 3'h2
		|=> regRdata == 8'h00) else $error("unmapped data");
	reset_quiet_a: assert property ($rose(rst_n) |-> !irqOut && !regRvalid)
		else $error("reset not quiet");
	rdata_hold_a: assert property (!regRvalid && $past(rst_n)
		|-> $stable(regRdata)) else $error("read data moved");
	// main scenarios
	cover property (wr ##1 rd && regAddr == OFS_MASK_HI);
	cover property (irqOut ##1 !irqOut);
	cover property (evtFieldExit ##1 rd && regAddr == OFS_STAT_LO);
endmodule : tism_irq_monitor
bind tism_irq tism_irq_monitor i_mon (.ref_clk, .rst_n, .regSel, .regWrite,
	.regAddr, .regWdata, .regRdata, .regRvalid, .evtFieldExit, .irqOut);

// ---- tism_host.sv ----
module tism_host (
	// request lines
	output logic regSel,
	output logic regWrite,
	output logic [4:0] regAddr,
	output logic [7:0] regWdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// one request per call; caller times it just after an edge
	task automatic drive(input logic [14:0] req);
		{regSel, regWrite, regAddr, regWdata} = req;
	endtask : drive
	initial drive(15'h0000);
endmodule : tism_host

// ---- tb.sv ----
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %0t %h %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0, rst_n = 1'b0, regSel, regWrite, regRvalid, irqOut, rd;
	logic [4:0] regAddr;
	logic [7:0] regWdata, regRdata;
	logic [31:0] r = '0, ev = '0;
	int seed = 72954, numChecks = 0, miscompares = 0, rexp, m[4] = '{4{0}};
	initial forever #12.5 ref_clk = ~ref_clk;
	tism_host i_host (.regSel, .regWrite, .regAddr, .regWdata);
	// ev: 16..0 events, 17/18 buffer qualifiers, 19 cfg load, 20 set-default
	tism_irq i_dut (.ref_clk, .rst_n, .regSel, .regWrite, .regAddr, .regWdata,
		.regRdata, .regRvalid, .nvmCfgValid(ev[19]), .nvm_mask_cfg_lo(r[31:24]),
		.nvm_mask_cfg_hi(r[23:16]), .cmdSetDefault(ev[20]), .evtInit(ev[16]),
		.evt_selected_wake(ev[15]), .evtSleepReq(ev[14]), .evtRxEnd(ev[11]),
		.evt_reader_write(ev[13]), .evt_reader_read(ev[12]), .evtTxEnd(ev[10]),
		.evtFieldExit(ev[9]), .evtRxStart(ev[8]), .evtFrameErr(ev[7]),
		.evtParityErr(ev[6]), .evtCrcErr(ev[5]), .evtBufUnderflow(ev[4]),
		.evtBufOverflow(ev[3]), .evtHostWrDone(ev[2]), .evtNvmAccErr(ev[1]),
		.evtAccCtrlErr(ev[0]), .rxToBuffer(ev[17]), .txFromBuffer(ev[18]),
		.irqOut);
	task automatic results();
		$display("%0d checks, %0d mismatches", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	// random traffic; m holds masks lo/hi then status lo/hi
	initial begin
		repeat (8) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 3000; i++) begin
			r = $random(seed);
			ev = $random(seed) & $random(seed) & $random(seed);
			i_host.drive({r[3], r[4], 5'h07 + 5'(r[2:0]), r[15:8]});
			@(posedge ref_clk);
			rd = regSel && !regWrite;
			rexp = regAddr[4:2] == 3'h2 ? m[regAddr[1:0]] : 0;
			if (ev[20] || rd && regAddr == 5'h0A) m[2] = 0;
			if (ev[20] || rd && regAddr == 5'h0B) m[3] = 0;
			m[2] |= {ev[16:12], ev[11] & ev[17], ev[10] & ev[18], ev[9]};
			m[3] |= {ev[8] & ev[17], ev[7:5], ev[4] | ev[3], ev[2:0]};
			if ({regSel, regWrite, regAddr[4:1]} == 6'h34) m[regAddr[0]] = regWdata;
			if (ev[19] || ev[20]) m[0] = m[0] & 8'hE7 | r[31:24] & 8'h18;
			if (ev[19] || ev[20]) m[1] = m[1] & 8'hE7 | r[23:16] & 8'h18;
			#1;
			`CHK(regRvalid, rd)
			if (rd) `CHK(regRdata, rexp[7:0])
			`CHK(irqOut, |(m[2] & ~m[0] | m[3] & ~m[1]))
		end
		results();
	end
endmodule : tb
